// File: swg_pkg.sv
// Shared constants and types for the serial write-guard memory link.
package swg_pkg;

  // ---------------------------------------------------------------
  // Word, address and frame layout
  // ---------------------------------------------------------------
  localparam int unsigned SWG_DW         = 16;
  localparam int unsigned SWG_AW         = 6;
  localparam int unsigned SWG_WORDS_LG   = 64;
  localparam int unsigned SWG_WORDS_SM   = 16;
  localparam int unsigned SWG_HDR_W      = 8;   // Opcode and address after the start bit.
  localparam int unsigned SWG_OP_LSB     = 6;
  localparam int unsigned SWG_SUB_LSB    = 4;
  localparam int unsigned SWG_SHORT_BITS = 9;
  localparam int unsigned SWG_LONG_BITS  = 25;
  localparam int unsigned SWG_RD_FIRST   = 10;  // First clock whose rise shows a read data bit.
  localparam int unsigned SWG_CNT_W      = 8;
  localparam logic [5:0]  SWG_SM_MASK    = 6'h0f;
  localparam logic [15:0] SWG_ERASED     = 16'hffff;

  // ---------------------------------------------------------------
  // Opcodes and extended sub-codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SWG_OP_EXT   = 2'h0;
  localparam logic [1:0] SWG_OP_WRITE = 2'h1;
  localparam logic [1:0] SWG_OP_READ  = 2'h2;
  localparam logic [1:0] SWG_OP_ERASE = 2'h3;
  localparam logic [1:0] SWG_SUB_DIS  = 2'h0;
  localparam logic [1:0] SWG_SUB_WRITE_ALL_CMD = 2'h1;
  localparam logic [1:0] SWG_SUB_ERASE_ALL_CMD = 2'h2;
  localparam logic [1:0] SWG_SUB_EN   = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned SWG_CLK_NS       = 10;
  localparam int unsigned SWG_PROG_TIME_US = 2000;
  localparam int unsigned SWG_PROG_CYC     = SWG_PROG_TIME_US * 1000 / SWG_CLK_NS;
  localparam int unsigned SWG_SK_HALF_NS   = 40;
  localparam int unsigned SWG_SK_HALF_CYC  = (SWG_SK_HALF_NS + SWG_CLK_NS - 1) / SWG_CLK_NS;
  localparam int unsigned SWG_GAP_NS       = 40;
  localparam int unsigned SWG_GAP_CYC      = (SWG_GAP_NS + SWG_CLK_NS - 1) / SWG_CLK_NS;
  localparam int unsigned SWG_HOLD_NS      = 200;
  localparam int unsigned SWG_HOLD_CYC     = (SWG_HOLD_NS + SWG_CLK_NS - 1) / SWG_CLK_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SWG_CMD_READ  = 3'h0,
    SWG_CMD_WRITE = 3'h1,
    SWG_CMD_ERASE = 3'h2,
    SWG_CMD_ERASE_ALL_CMD  = 3'h3,
    SWG_CMD_WRITE_ALL_CMD  = 3'h4,
    SWG_CMD_EN    = 3'h5,
    SWG_CMD_DIS   = 3'h6
  } swg_cmd_t;

  typedef enum logic [2:0] {
    SWG_M_IDLE = 3'h0,
    SWG_M_HDR  = 3'h1,
    SWG_M_DATA = 3'h2,
    SWG_M_READ = 3'h3,
    SWG_M_DONE = 3'h4
  } swg_mst_t;

  typedef enum logic [2:0] {
    SWG_H_IDLE  = 3'h0,
    SWG_H_FRAME = 3'h1,
    SWG_H_GAP   = 3'h2,
    SWG_H_HOLD  = 3'h3,
    SWG_H_WAIT  = 3'h4
  } swg_hst_t;

  typedef enum logic [1:0] {
    SWG_STEP_EN  = 2'h0,
    SWG_STEP_CMD = 2'h1,
    SWG_STEP_DIS = 2'h2
  } swg_step_t;

endpackage

// File: swg_link_if.sv
// Serial link between the host controller and the guarded memory.
`timescale 1ns/1ns
interface swg_link_if;
  logic chip_sel;         // Frame select, high during a command.
  logic serial_clock_in;  // Link clock made by the host.
  logic data_to_mem;      // Serial data toward the memory.
  logic data_from_mem;    // Serial read data from the memory.
  logic mem_ready;        // High when no programming cycle runs.

  modport host (output chip_sel, serial_clock_in, data_to_mem, input data_from_mem, mem_ready);
  modport mem  (input chip_sel, serial_clock_in, data_to_mem, output data_from_mem, mem_ready);
endinterface

// File: swg_mem_end.sv
// Memory end of the serial write-guard link: decoder, word array, enable state and program timer.
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Summary of operation
// - Disable command: read-only, pump off.
// - Reads work normally in read-only mode.
// - Erase and write commands ignored while disabled.
// - Power-up starts in read-only mode.
// - Host disables programming soon after power-up.
// - Host enables just before each programming command.
// - Host disables right after each programming command.
// - Host disables before the supply sags.
// - Sixteen or sixty-four sixteen-bit words.
// - Larger variant self-times and shows busy.
// ---------------------------------------------------------------
module swg_mem_end
  import swg_pkg::*;
#(
  parameter bit          LARGE_VARIANT = 1'b1,
  parameter int unsigned PROG_CYC      = SWG_PROG_CYC
) (
  // Link to the host.
  swg_link_if.mem          link,
  // Core clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Status toward the core.
  output logic             o_prog_en,
  output logic             o_pump_on,
  output logic             o_busy
);

  localparam int unsigned WORDS = LARGE_VARIANT ? SWG_WORDS_LG : SWG_WORDS_SM;

  // Small variant folds the address onto its sixteen words.
  function automatic logic [SWG_AW-1:0] word_idx(input logic [SWG_AW-1:0] a);
    word_idx = LARGE_VARIANT ? a : (a & SWG_SM_MASK);
  endfunction

  // Extended opcode test shared by the decoders.
  function automatic logic is_ext(input logic [1:0] op, input logic [1:0] sb, input logic [1:0] want);
    is_ext = (op == SWG_OP_EXT) && (sb == want);
  endfunction

  // ---------------------------------------------------------------
  // Link-clock domain
  // ---------------------------------------------------------------
  swg_mst_t                 st_r;
  logic [4:0]               cnt_r;
  logic [SWG_HDR_W-1:0]     hdr_r;
  logic [SWG_DW-1:0]        dat_r;
  logic [SWG_DW-1:0]        rd_r;
  logic [SWG_AW-1:0]        addr_r;
  logic                     all_r;
  logic                     dout_r;
  logic                     en_r;
  logic                     tgl_r;
  logic [SWG_DW-1:0]        mem_r [WORDS];
  logic                     frame_rst_n;
  logic [SWG_HDR_W-1:0]     hdr_full;
  logic [1:0]               opc;
  logic [SWG_AW-1:0]        adr;
  logic [1:0]               sub;
  logic                     last_hdr;
  logic                     last_dat;
  logic                     go_data;
  logic                     go_read;
  logic                     do_en;
  logic                     do_dis;
  logic                     do_erase;
  logic                     do_erase_all_cmd;
  logic                     do_wr;
  logic [SWG_DW-1:0]        wr_word;

  // A low select ends the frame even though the link clock stops.
  assign frame_rst_n = i_rst_n & link.chip_sel;

  // Header fields as they stand with the current input bit.
  assign hdr_full = {hdr_r[SWG_HDR_W-2:0], link.data_to_mem};
  assign opc      = hdr_full[SWG_HDR_W-1:SWG_OP_LSB];
  assign adr      = hdr_full[SWG_AW-1:0];
  assign sub      = adr[SWG_AW-1:SWG_SUB_LSB];
  assign last_hdr = (st_r == SWG_M_HDR) && (cnt_r == 5'(SWG_HDR_W - 1));
  assign last_dat = (st_r == SWG_M_DATA) && (cnt_r == 5'(SWG_DW - 1));
  assign wr_word  = {dat_r[SWG_DW-2:0], link.data_to_mem};

  // Command decode; programming actions need the enable state.
  assign go_read  = last_hdr && (opc == SWG_OP_READ);
  assign do_en    = last_hdr && is_ext(opc, sub, SWG_SUB_EN);
  assign do_dis   = last_hdr && is_ext(opc, sub, SWG_SUB_DIS);
  assign go_data  = last_hdr && en_r && ((opc == SWG_OP_WRITE) || is_ext(opc, sub, SWG_SUB_WRITE_ALL_CMD));
  assign do_erase = last_hdr && en_r && (opc == SWG_OP_ERASE);
  assign do_erase_all_cmd  = last_hdr && en_r && is_ext(opc, sub, SWG_SUB_ERASE_ALL_CMD);
  assign do_wr    = last_dat;

  // Frame sequencer: start bit, header, then data in or data out.
  always_ff @(posedge link.serial_clock_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      st_r  <= SWG_M_IDLE;
      cnt_r <= '0;
      hdr_r <= '0;
    end else begin
      case (st_r)
        SWG_M_IDLE: begin
          if (link.data_to_mem) begin
            st_r  <= SWG_M_HDR;
            cnt_r <= '0;
          end
        end
        SWG_M_HDR: begin
          hdr_r <= hdr_full;
          cnt_r <= cnt_r + 5'h1;
          if (last_hdr) begin
            cnt_r <= '0;
            st_r  <= go_read ? SWG_M_READ : (go_data ? SWG_M_DATA : SWG_M_DONE);
          end
        end
        SWG_M_DATA, SWG_M_READ: begin
          cnt_r <= cnt_r + 5'h1;
          if (cnt_r == 5'(SWG_DW - 1)) begin
            st_r <= SWG_M_DONE;
          end
        end
        SWG_M_DONE: st_r <= SWG_M_DONE;
        default:    st_r <= SWG_M_IDLE;
      endcase
    end
  end

  // Data path: write shift, read shift and the output bit.
  always_ff @(posedge link.serial_clock_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      dat_r  <= '0;
      rd_r   <= '0;
      addr_r <= '0;
      all_r  <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      if (last_hdr) begin
        addr_r <= word_idx(adr);
        all_r  <= (opc == SWG_OP_EXT);
        rd_r   <= mem_r[word_idx(adr)];
        dout_r <= 1'b0;                 // Dummy bit ahead of the word.
      end else if (st_r == SWG_M_READ) begin
        dout_r <= rd_r[SWG_DW-1];
        rd_r   <= {rd_r[SWG_DW-2:0], 1'b0};
      end else begin
        dout_r <= 1'b0;
      end
      if (st_r == SWG_M_DATA) begin
        dat_r <= wr_word;
      end
    end
  end

  // Enable state survives frames; only disable or power loss clears it.
  always_ff @(posedge link.serial_clock_in or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_r  <= 1'b0;
      tgl_r <= 1'b0;
    end else begin
      if (do_en) begin
        en_r <= 1'b1;
      end else if (do_dis) begin
        en_r <= 1'b0;
      end
      tgl_r <= tgl_r ^ (do_erase | do_erase_all_cmd | do_wr);
    end
  end

  // Word array; erase fills ones, write-all and erase-all cover every word.
  always_ff @(posedge link.serial_clock_in) begin
    for (int i = 0; i < WORDS; i++) begin
      if (do_erase_all_cmd || (do_wr && all_r)) begin
        mem_r[i] <= do_wr ? wr_word : SWG_ERASED;
      end else if ((do_erase && word_idx(adr) == SWG_AW'(i)) || (do_wr && addr_r == SWG_AW'(i))) begin
        mem_r[i] <= do_wr ? wr_word : SWG_ERASED;
      end
    end
  end

  assign link.data_from_mem = dout_r;

  // ---------------------------------------------------------------
  // Core-clock domain
  // ---------------------------------------------------------------
  logic [2:0]  tsync_r;
  logic [2:0]  esync_r;
  logic        tgl_seen_r;
  logic        prog_en_r;
  logic        busy_r;
  logic [31:0] prog_cnt_r;
  logic        prog_evt;

  // Three-stage synchronisers for the program toggle and the enable level.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tsync_r <= '0;
      esync_r <= '0;
    end else begin
      tsync_r <= {tsync_r[1:0], tgl_r};
      esync_r <= {esync_r[1:0], en_r};
    end
  end

  // A toggle counts once the last two stages agree on a new value.
  assign prog_evt = (tsync_r[1] == tsync_r[2]) && (tsync_r[2] != tgl_seen_r);

  // Enable level and pump follow the agreed synchronised state.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prog_en_r  <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      if (esync_r[1] == esync_r[2]) begin
        prog_en_r <= esync_r[2];
      end
      if (prog_evt) begin
        tgl_seen_r <= tsync_r[2];
      end
    end
  end

  // Self-timed programming cycle on the larger variant.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_r     <= 1'b0;
      prog_cnt_r <= '0;
    end else if (prog_evt && LARGE_VARIANT) begin
      busy_r     <= 1'b1;
      prog_cnt_r <= 32'(PROG_CYC - 1);
    end else if (prog_cnt_r != '0) begin
      prog_cnt_r <= prog_cnt_r - 32'h1;
    end else begin
      busy_r <= 1'b0;
    end
  end

  assign link.mem_ready = ~busy_r;
  assign o_busy         = busy_r;
  assign o_prog_en      = prog_en_r;
  assign o_pump_on      = prog_en_r;

endmodule // swg_mem_end

// File: swg_host_end.sv
// Host end of the serial write-guard link: command sequencer and link clock generator.
`timescale 1ns/1ns
module swg_host_end
  import swg_pkg::*;
(
  // Core clock and reset.
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  // Command request.
  input  wire logic          i_cmd_valid,
  input  swg_cmd_t           i_cmd_op,
  input  wire logic [5:0]    i_cmd_addr,
  input  wire logic [15:0]   i_cmd_data,
  output logic               o_cmd_ready,
  // Read answer and status.
  output logic               o_rd_valid,
  output logic [15:0]        o_rd_data,
  output logic               o_busy,
  // Supply monitor.
  input  wire logic          i_supply_low,
  // Link to the memory.
  swg_link_if.host           link
);

  // Programming commands are the ones wrapped by enable and disable.
  function automatic logic is_prog(input swg_cmd_t c);
    is_prog = (c == SWG_CMD_WRITE) || (c == SWG_CMD_ERASE) || (c == SWG_CMD_ERASE_ALL_CMD) || (c == SWG_CMD_WRITE_ALL_CMD);
  endfunction

  // Frame bits, start bit first, data left-aligned after the header.
  function automatic logic [SWG_LONG_BITS-1:0] frame_of(input swg_cmd_t c, input logic [5:0] a,
                                                        input logic [15:0] d);
    logic [1:0]  op;
    logic [5:0]  ad;
    logic [15:0] dd;
    op = SWG_OP_EXT;
    ad = {SWG_SUB_DIS, 4'h0};
    dd = '0;
    case (c)
      SWG_CMD_READ:  begin op = SWG_OP_READ;  ad = a; end
      SWG_CMD_WRITE: begin op = SWG_OP_WRITE; ad = a; dd = d; end
      SWG_CMD_ERASE: begin op = SWG_OP_ERASE; ad = a; end
      SWG_CMD_ERASE_ALL_CMD:  ad = {SWG_SUB_ERASE_ALL_CMD, 4'h0};
      SWG_CMD_WRITE_ALL_CMD:  begin ad = {SWG_SUB_WRITE_ALL_CMD, 4'h0}; dd = d; end
      SWG_CMD_EN:    ad = {SWG_SUB_EN, 4'h0};
      default:       ad = {SWG_SUB_DIS, 4'h0};
    endcase
    frame_of = {1'b1, op, ad, dd};
  endfunction

  // Link clocks needed by each command.
  function automatic logic [4:0] bits_of(input swg_cmd_t c);
    bits_of = (c == SWG_CMD_READ || c == SWG_CMD_WRITE || c == SWG_CMD_WRITE_ALL_CMD) ?
              5'(SWG_LONG_BITS) : 5'(SWG_SHORT_BITS);
  endfunction

  swg_hst_t                  st_r;
  swg_step_t                 step_r;
  swg_cmd_t                  op_r;
  logic [5:0]                addr_r;
  logic [15:0]               data_r;
  logic [SWG_LONG_BITS-1:0]  tx_r;
  logic [4:0]                nbits_r;
  logic [4:0]                bit_r;
  logic [SWG_CNT_W-1:0]      tmr_r;
  logic                      cs_r;
  logic                      sk_r;
  logic                      di_r;
  logic [15:0]               rx_r;
  logic                      rdv_r;
  logic [15:0]               rdd_r;
  logic                      pend_dis_r;
  logic [2:0]                rsync_r;
  logic [2:0]                lsync_r;
  logic                      rdy_r;
  logic                      low_r;
  logic                      launch;
  swg_cmd_t                  launch_c;
  logic [5:0]                launch_a;
  logic [15:0]               launch_d;
  logic                      dis_done;
  logic [4:0]                bit_nxt;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsync_r <= '0;
      lsync_r <= '0;
      rdy_r   <= 1'b0;
      low_r   <= 1'b0;
    end else begin
      rsync_r <= {rsync_r[1:0], link.mem_ready};
      lsync_r <= {lsync_r[1:0], i_supply_low};
      if (rsync_r[1] == rsync_r[2]) begin
        rdy_r <= rsync_r[2];
      end
      if (lsync_r[1] == lsync_r[2]) begin
        low_r <= lsync_r[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame selection
  // ---------------------------------------------------------------
  always_comb begin
    launch   = 1'b0;
    launch_c = SWG_CMD_DIS;
    launch_a = addr_r;
    launch_d = data_r;
    case (st_r)
      SWG_H_IDLE: begin
        if (pend_dis_r) begin
          launch = 1'b1;
        end else if (i_cmd_valid && !low_r) begin
          launch   = 1'b1;
          launch_c = is_prog(i_cmd_op) ? SWG_CMD_EN : i_cmd_op;
          launch_a = i_cmd_addr;
          launch_d = i_cmd_data;
        end
      end
      SWG_H_GAP: begin
        if (tmr_r == SWG_CNT_W'(SWG_GAP_CYC - 1) && step_r == SWG_STEP_EN) begin
          launch   = 1'b1;
          launch_c = op_r;
        end
      end
      SWG_H_WAIT: launch = rdy_r;
      default:    launch = 1'b0;
    endcase
  end

  assign dis_done = (st_r == SWG_H_GAP) && (tmr_r == SWG_CNT_W'(SWG_GAP_CYC - 1)) && (step_r == SWG_STEP_DIS);
  assign bit_nxt  = bit_r + 5'h1;

  // ---------------------------------------------------------------
  // Sequencer and link drive
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r    <= SWG_H_IDLE;
      step_r  <= SWG_STEP_DIS;
      op_r    <= SWG_CMD_READ;
      addr_r  <= '0;
      data_r  <= '0;
      tx_r    <= '0;
      nbits_r <= '0;
      bit_r   <= '0;
      tmr_r   <= '0;
      cs_r    <= 1'b0;
      sk_r    <= 1'b0;
      di_r    <= 1'b0;
      rx_r    <= '0;
      rdv_r   <= 1'b0;
      rdd_r   <= '0;
    end else begin
      rdv_r <= 1'b0;
      if (launch) begin
        tx_r    <= frame_of(launch_c, launch_a, launch_d) << 1;
        di_r    <= 1'b1;
        nbits_r <= bits_of(launch_c);
        bit_r   <= '0;
        tmr_r   <= '0;
        cs_r    <= 1'b1;
        sk_r    <= 1'b0;
        st_r    <= SWG_H_FRAME;
        // Only a wrapped programming command opens with the enable step; a raw enable must not relaunch itself.
        step_r  <= (st_r == SWG_H_GAP) ? SWG_STEP_CMD :
                   ((st_r == SWG_H_WAIT) || pend_dis_r) ? SWG_STEP_DIS :
                   (is_prog(i_cmd_op) ? SWG_STEP_EN : SWG_STEP_CMD);
        if (st_r == SWG_H_IDLE && !pend_dis_r) begin
          op_r   <= i_cmd_op;
          addr_r <= i_cmd_addr;
          data_r <= i_cmd_data;
        end
      end else begin
        case (st_r)
          SWG_H_FRAME: begin
            tmr_r <= tmr_r + SWG_CNT_W'(1);
            if (tmr_r == SWG_CNT_W'(SWG_SK_HALF_CYC - 1)) begin
              tmr_r <= '0;
              sk_r  <= ~sk_r;
              if (sk_r) begin
                bit_r <= bit_nxt;
                di_r  <= tx_r[SWG_LONG_BITS-1];
                tx_r  <= tx_r << 1;
                if (bit_nxt >= 5'(SWG_RD_FIRST)) begin
                  rx_r <= {rx_r[14:0], link.data_from_mem};
                end
                if (bit_nxt == nbits_r) begin
                  cs_r  <= 1'b0;
                  di_r  <= 1'b0;
                  st_r  <= SWG_H_GAP;
                  rdv_r <= (step_r == SWG_STEP_CMD) && (op_r == SWG_CMD_READ);
                  rdd_r <= {rx_r[14:0], link.data_from_mem};
                end
              end
            end
          end
          SWG_H_GAP: begin
            tmr_r <= tmr_r + SWG_CNT_W'(1);
            if (tmr_r == SWG_CNT_W'(SWG_GAP_CYC - 1)) begin
              tmr_r <= '0;
              st_r  <= (step_r == SWG_STEP_CMD && is_prog(op_r)) ? SWG_H_HOLD : SWG_H_IDLE;
            end
          end
          SWG_H_HOLD: begin
            tmr_r <= tmr_r + SWG_CNT_W'(1);
            if (tmr_r == SWG_CNT_W'(SWG_HOLD_CYC - 1)) begin
              st_r <= SWG_H_WAIT;
            end
          end
          SWG_H_WAIT: st_r <= SWG_H_WAIT;
          default:    st_r <= SWG_H_IDLE;
        endcase
      end
    end
  end

  // Disable owed after reset or supply loss; a new demand wins over completion.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_dis_r <= 1'b1;
    end else if (low_r) begin
      pend_dis_r <= (st_r == SWG_H_IDLE) ? 1'b1 : (pend_dis_r | ~dis_done);
    end else if (dis_done) begin
      pend_dis_r <= 1'b0;
    end
  end

  assign o_cmd_ready          = (st_r == SWG_H_IDLE) && !pend_dis_r && !low_r;
  assign o_busy               = (st_r != SWG_H_IDLE);
  assign o_rd_valid           = rdv_r;
  assign o_rd_data            = rdd_r;
  assign link.chip_sel        = cs_r;
  assign link.serial_clock_in = sk_r;
  assign link.data_to_mem     = di_r;

endmodule // swg_host_end

// File: swg_link_sva.sv
// Checker for the write-guard link and the memory end status.
`timescale 1ns/1ns
module swg_link_sva #(
  parameter int PROG_CYC = 50
) (
  // Clock, reset and watched signals.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic chip_sel,
  input wire logic data_from_mem,
  input wire logic mem_ready,
  input wire logic o_prog_en,
  input wire logic o_pump_on,
  input wire logic o_busy
);
  logic [15:0] low_cnt_r;
  logic [3:0]  idle_cnt_r;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Counts the cycles of one programming cycle.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) low_cnt_r <= '0;
    else if (mem_ready) low_cnt_r <= '0;
    else low_cnt_r <= low_cnt_r + 16'h0001;
  end
  // Counts idle link cycles, saturating, so enable changes can be tied to frames.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) idle_cnt_r <= '0;
    else if (chip_sel) idle_cnt_r <= '0;
    else if (idle_cnt_r != 4'hf) idle_cnt_r <= idle_cnt_r + 4'h1;
  end
  a_pump_follows_en: assert property (o_pump_on == o_prog_en)
    else $error("pump and enable differ");
  a_reset_read_only: assert property ($rose(i_rst_n) |-> !o_prog_en && mem_ready)
    else $error("not read-only after reset");
  a_ready_not_busy: assert property (mem_ready == !o_busy)
    else $error("ready and busy disagree");
  a_prog_needs_en: assert property ($fell(mem_ready) |-> o_prog_en)
    else $error("programming while disabled");
  a_prog_length: assert property ($rose(mem_ready) |-> low_cnt_r >= PROG_CYC - 3 && low_cnt_r <= PROG_CYC + 3)
    else $error("programming cycle length wrong");
  a_en_held_idle: assert property ($changed(o_prog_en) |-> idle_cnt_r < 4'h8)
    else $error("enable changed with link idle");
  a_read_idle_zero: assert property (!chip_sel && !$past(chip_sel) |-> !data_from_mem)
    else $error("read data outside a frame");
  a_link_quiet_busy: assert property ($fell(mem_ready) |-> ##[0:4] (!chip_sel) [*8])
    else $error("frame sent during programming");
endmodule // swg_link_sva

// File: serial_eeprom_write_guard_bench.sv
// Self-checking bench joining the host end and the memory end.
`timescale 1ns/1ns
module serial_eeprom_write_guard_bench;
  import swg_pkg::*;
  logic        i_core_clk;
  logic        i_rst_n;
  logic        i_cmd_valid;
  swg_cmd_t    i_cmd_op;
  logic [5:0]  i_cmd_addr;
  logic [15:0] i_cmd_data;
  logic        i_supply_low;
  logic        cmd_ready;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic        hbusy;
  logic        prog_en;
  logic        pump_on;
  logic        mbusy;
  logic        en_at_busy;
  logic [15:0] model [64];
  logic [5:0]  wa [$];
  logic [31:0] seed;
  int          fail_count;
  int          n_compared;
  swg_link_if link ();
  swg_mem_end #(.LARGE_VARIANT(1'b1), .PROG_CYC(50)) u_swg_mem_end (.link(link.mem), .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .o_prog_en(prog_en), .o_pump_on(pump_on), .o_busy(mbusy));
  swg_host_end u_swg_host_end (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data), .o_cmd_ready(cmd_ready),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_busy(hbusy), .i_supply_low(i_supply_low), .link(link.host));
  swg_link_sva #(.PROG_CYC(50)) u_swg_link_sva (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .chip_sel(link.chip_sel), .data_from_mem(link.data_from_mem), .mem_ready(link.mem_ready),
    .o_prog_en(prog_en), .o_pump_on(pump_on), .o_busy(mbusy));
  // Next random value of the xorshift sequence.
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  // Word and flag comparisons.
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk16(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Issues one command and waits, bounded, for its answer.
  task automatic do_cmd(input swg_cmd_t op, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge i_core_clk);
    i_cmd_valid = 1'b1;
    i_cmd_op    = op;
    i_cmd_addr  = a;
    i_cmd_data  = d;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge i_core_clk);
      n++;
    end
    @(negedge i_core_clk);
    i_cmd_valid = 1'b0;
    n = 0;
    en_at_busy = 1'b0;
    while ((hbusy !== 1'b0 || (op == SWG_CMD_READ && rd_valid !== 1'b1)) && n < 3000) begin
      if (op == SWG_CMD_READ && rd_valid === 1'b1) break;
      if (mbusy === 1'b1) en_at_busy = prog_en;
      @(negedge i_core_clk);
      n++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    do_cmd(SWG_CMD_WRITE, a, d);
    chk1("enable while programming", 1'b1, en_at_busy);
    model[a] = d;
    wa.push_back(a);
  endtask
  task automatic rd(input logic [5:0] a);
    do_cmd(SWG_CMD_READ, a, 16'h0000);
    chk16("read word", model[a], rd_data);
  endtask
  // Clock and watchdog.
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    #(40000 * 10);
    fail_count++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    i_rst_n = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd_op = SWG_CMD_READ;
    i_cmd_addr = 6'h00;
    i_cmd_data = 16'h0000;
    i_supply_low = 1'b0;
    seed = 32'h00000009;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    @(negedge i_core_clk);
    chk1("enable at power-up", 1'b0, prog_en);
    chk1("ready before disable", 1'b0, cmd_ready);
    wr(6'h00, 16'h0000);
    wr(6'h3f, 16'hffff);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr(seed[5:0], seed[31:16]);
    end
    chk1("enable after write", 1'b0, prog_en);
    foreach (wa[i]) rd(wa[i]);
    do_cmd(SWG_CMD_ERASE, wa[2], 16'h0000);
    model[wa[2]] = 16'hffff;
    rd(wa[2]);
    do_cmd(SWG_CMD_EN, 6'h00, 16'h0000);
    chk1("pump when enabled", 1'b1, pump_on);
    rd(6'h3f);
    chk1("enable held", 1'b1, prog_en);
    do_cmd(SWG_CMD_DIS, 6'h00, 16'h0000);
    chk1("pump when disabled", 1'b0, pump_on);
    rd(6'h00);
    i_supply_low = 1'b1;
    repeat (150) @(negedge i_core_clk);
    chk1("ready during sag", 1'b0, cmd_ready);
    chk1("enable during sag", 1'b0, prog_en);
    i_supply_low = 1'b0;
    do_cmd(SWG_CMD_ERASE_ALL_CMD, 6'h00, 16'h0000);
    chk1("busy seen on erase-all", 1'b1, en_at_busy);
    foreach (model[i]) model[i] = 16'hffff;
    rd(seed[13:8]);
    seed = xs(seed);
    do_cmd(SWG_CMD_WRITE_ALL_CMD, 6'h00, seed[15:0]);
    foreach (model[i]) model[i] = seed[15:0];
    rd(6'h00);
    rd(6'h3f);
    end_of_test();
  end
endmodule // serial_eeprom_write_guard_bench
